//--- rtl/teach_control_sequencer.sv
// Teach sequencer: buttons, teach input, LEDs, outputs, AXI4-Lite registers
//
// Functional notes
// - Release after entering analog teach captures first point, stays in teach.
// - Next brief press captures second point and ends the teach.
// - Near then far gives rising curve; far then near gives falling.
// - Points closer than 40 mm (400 range) or 130 mm (1300) are faulty.
// - Faulty analog teach flashes both LEDs at 8 Hz until a good teach.
// - Out-of-range objects give distinct too-close and too-far analog codes.
// - After reset the multipurpose line acts as the teach input.
// - Teach input held high locks out both buttons.
// - Teach input low or open leaves the buttons usable.
// - Teach-input two-point teach sets window and analog curve together.
// - Teach input never changes switching polarity or curve direction.
// - Configuration and diagnostics are readable through the register port.
// - Single-point teach stores the present distance as switching point.
// - Switching output stays inactive while a switching teach error stands.
`timescale 1ns/10ps
module teach_control_sequencer #(
	parameter int TICK_CYCLES = teach_pkg::TICK_CYCLES_DEF
) (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        button1_pin,
	input  wire logic        button2_pin,
	input  wire logic        teach_in_pin,
	input  wire logic [15:0] dist_mm,
	input  wire logic        dist_valid,
	output logic             switching_output,
	output logic [15:0]      analog_output,
	output logic             analog_too_close,
	output logic             analog_too_far,
	output logic             led_yellow,
	output logic             led_green,
	output logic             irq,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import teach_pkg::*;

	if (TICK_CYCLES < 2) begin : g_chk
		$error("TICK_CYCLES must be at least 2");
	end

	// ************************************************************
	// Millisecond tick and debounced inputs
	// ************************************************************
	logic [31:0] div_ff;
	logic        tick_ff;
	logic [2:0]  db_level;
	logic [2:0]  db_prev_ff;
	logic [2:0]  raw_pins;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			div_ff  <= 32'h0;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= (div_ff == 32'(TICK_CYCLES - 1));
			div_ff  <= (div_ff == 32'(TICK_CYCLES - 1)) ? 32'h0 : div_ff + 32'h1;
		end
	end

	assign raw_pins = {teach_in_pin, button2_pin, button1_pin};

	for (genvar i = 0; i < 3; i++) begin : g_db
		input_debounce #(.STABLE_TICKS(DEBOUNCE_MS)) u_db (
			.sys_clk (sys_clk),
			.sys_rst (sys_rst),
			.tick    (tick_ff),
			.pin     (raw_pins[i]),
			.level   (db_level[i])
		);
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) db_prev_ff <= 3'b000;
		else         db_prev_ff <= db_level;
	end

	// ************************************************************
	// Configuration registers
	// ************************************************************
	logic [1:0]  ctrl_ff;
	logic [3:0]  int_stat_ff;
	logic [3:0]  int_mask_ff;
	logic [31:0] ti_single_ff;
	logic [31:0] ti_pair_ff;
	logic        ti_enable;
	logic        range_1300;
	logic        buttons_locked;

	assign ti_enable      = ctrl_ff[0];
	assign range_1300     = ctrl_ff[1];
	assign buttons_locked = ti_enable & db_level[2];

	// ************************************************************
	// Sequencer
	// ************************************************************
	seq_state_t   state_ff;
	pair_target_t tgt_ff;
	logic         hold_btn2_ff;
	logic [13:0]  press_ms_ff;
	logic [13:0]  ti_ms_ff;
	logic [15:0]  p1_ff;
	logic [15:0]  ana_start_ff;
	logic [15:0]  ana_end_ff;
	logic [15:0]  sw_p1_ff;
	logic [15:0]  sw_p2_ff;
	logic         curve_falling_ff;
	logic         nc_mode_ff;
	logic         window_mode_ff;
	logic         ana_err_ff;
	logic         sw_err_ff;
	logic [3:0]   ev_ff;

	logic         b1_rel;
	logic         b2_rel;
	logic         any_press;
	logic         ti_fall;
	logic         ti_single;
	logic         ti_pair;
	logic [15:0]  p_lo;
	logic [15:0]  p_hi;
	logic         pair_bad;

	assign b1_rel    = ~buttons_locked & db_prev_ff[0] & ~db_level[0];
	assign b2_rel    = ~buttons_locked & db_prev_ff[1] & ~db_level[1];
	assign any_press = ~buttons_locked & ((db_level[0] & ~db_prev_ff[0])
		| (db_level[1] & ~db_prev_ff[1]));
	assign ti_fall   = ti_enable & db_prev_ff[2] & ~db_level[2];
	// Pulse length windows, {max, min} in ms, max exclusive
	assign ti_single = ti_fall & ({2'b00, ti_ms_ff} >= ti_single_ff[15:0])
		& ({2'b00, ti_ms_ff} < ti_single_ff[31:16]);
	assign ti_pair   = ti_fall & ({2'b00, ti_ms_ff} >= ti_pair_ff[15:0])
		& ({2'b00, ti_ms_ff} < ti_pair_ff[31:16]);
	assign p_lo      = (p1_ff < dist_mm) ? p1_ff : dist_mm;
	assign p_hi      = (p1_ff < dist_mm) ? dist_mm : p1_ff;
	assign pair_bad  = ~dist_valid
		| ((p_hi - p_lo) < (range_1300 ? MIN_GAP_1300_MM : MIN_GAP_400_MM));

	// Press and pulse timers saturate so very long holds stay classified
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			press_ms_ff <= 14'h0;
			ti_ms_ff    <= 14'h0;
		end else begin
			if (!(db_level[0] | db_level[1]))
				press_ms_ff <= 14'h0;
			else if (tick_ff && press_ms_ff != 14'h3FFF)
				press_ms_ff <= press_ms_ff + 14'h1;
			if (!db_level[2])
				ti_ms_ff <= 14'h0;
			else if (tick_ff && ti_ms_ff != 14'h3FFF)
				ti_ms_ff <= ti_ms_ff + 14'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_ff         <= SEQ_IDLE;
			tgt_ff           <= TGT_ANALOG;
			hold_btn2_ff     <= 1'b0;
			p1_ff            <= 16'h0;
			ana_start_ff     <= 16'h0;
			ana_end_ff       <= 16'h0;
			sw_p1_ff         <= 16'h0;
			sw_p2_ff         <= 16'h0;
			curve_falling_ff <= 1'b0;
			nc_mode_ff       <= 1'b0;
			window_mode_ff   <= 1'b0;
			ana_err_ff       <= 1'b0;
			sw_err_ff        <= 1'b0;
			ev_ff            <= 4'h0;
		end else begin
			ev_ff <= 4'h0;
			unique case (state_ff)
				SEQ_IDLE: begin
					if (any_press) begin
						state_ff     <= SEQ_HOLD;
						hold_btn2_ff <= db_level[1];
					end else if (ti_single) begin
						sw_p1_ff       <= dist_mm;
						window_mode_ff <= 1'b0;
						sw_err_ff      <= ~dist_valid;
						ev_ff[dist_valid ? EV_SW_DONE : EV_SW_ERR] <= 1'b1;
					end else if (ti_pair) begin
						p1_ff    <= dist_mm;
						tgt_ff   <= TGT_BOTH;
						state_ff <= SEQ_PAIR;
					end
				end
				SEQ_HOLD: begin
					if (buttons_locked) begin
						state_ff <= SEQ_IDLE;
					end else if (b1_rel && !hold_btn2_ff) begin
						state_ff <= SEQ_IDLE;
						if (press_ms_ff > PAIR_MAX_MS) begin
							nc_mode_ff <= ~nc_mode_ff;
						end else if (press_ms_ff >= PAIR_MIN_MS) begin
							p1_ff    <= dist_mm;
							tgt_ff   <= TGT_WINDOW;
							state_ff <= SEQ_PAIR;
						end else if (press_ms_ff >= SINGLE_MIN_MS) begin
							sw_p1_ff       <= dist_mm;
							window_mode_ff <= 1'b0;
							sw_err_ff      <= ~dist_valid;
							ev_ff[dist_valid ? EV_SW_DONE : EV_SW_ERR] <= 1'b1;
						end
					end else if (b2_rel && hold_btn2_ff) begin
						// Holds outside 7..12 s are dropped
						if (press_ms_ff >= PAIR_MIN_MS && press_ms_ff <= PAIR_MAX_MS) begin
							p1_ff    <= dist_mm;
							tgt_ff   <= TGT_ANALOG;
							state_ff <= SEQ_PAIR;
						end else begin
							state_ff <= SEQ_IDLE;
						end
					end
				end
				SEQ_PAIR: begin
					// Second point: brief press of the button that started it, or a second pair pulse on the teach input
					if ((tgt_ff == TGT_ANALOG && b2_rel) || (tgt_ff == TGT_WINDOW && b1_rel)
						|| (tgt_ff == TGT_BOTH && ti_pair)) begin
						state_ff <= SEQ_IDLE;
						if (tgt_ff != TGT_WINDOW) begin
							ana_err_ff <= pair_bad;
							ev_ff[pair_bad ? EV_ANA_ERR : EV_ANA_DONE] <= 1'b1;
							if (!pair_bad) begin
								ana_start_ff <= p_lo;
								ana_end_ff   <= p_hi;
								// Direction only from button order
								if (tgt_ff == TGT_ANALOG)
									curve_falling_ff <= (dist_mm < p1_ff);
							end
						end
						if (tgt_ff != TGT_ANALOG) begin
							sw_err_ff <= pair_bad;
							ev_ff[pair_bad ? EV_SW_ERR : EV_SW_DONE] <= 1'b1;
							if (!pair_bad) begin
								sw_p1_ff       <= p_lo;
								sw_p2_ff       <= p_hi;
								window_mode_ff <= 1'b1;
							end
						end
					end else if (tgt_ff != TGT_BOTH && buttons_locked) begin
						state_ff <= SEQ_IDLE;
					end
				end
				default: state_ff <= SEQ_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Outputs from distance
	// ************************************************************
	logic sw_cond;

	assign sw_cond = window_mode_ff ? (dist_mm >= sw_p1_ff && dist_mm <= sw_p2_ff)
		: (dist_mm <= sw_p1_ff);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			switching_output <= 1'b0;
			analog_output    <= 16'h0;
			analog_too_close <= 1'b0;
			analog_too_far   <= 1'b0;
		end else begin
			switching_output <= ~sw_err_ff & dist_valid & (sw_cond ^ nc_mode_ff);
			analog_too_close <= dist_mm < ana_start_ff;
			analog_too_far   <= dist_mm > ana_end_ff;
			if (dist_mm < ana_start_ff)
				analog_output <= ANA_CLOSE_CODE;
			else if (dist_mm > ana_end_ff)
				analog_output <= ANA_FAR_CODE;
			else if (curve_falling_ff)
				analog_output <= ana_end_ff - dist_mm;
			else
				analog_output <= dist_mm - ana_start_ff;
		end
	end

	// ************************************************************
	// Indicator LEDs
	// ************************************************************
	logic [8:0] flash_ms_ff;
	logic       phase_ff;
	logic [8:0] half_ms;
	logic       teach_flash;

	assign teach_flash = (state_ff == SEQ_PAIR)
		|| (state_ff == SEQ_HOLD && press_ms_ff >= PAIR_MIN_MS);
	assign half_ms = teach_flash ? HALF_TEACH_MS
		: (state_ff == SEQ_HOLD) ? HALF_TEACH_MS
		: ana_err_ff ? HALF_ANERR_MS : HALF_SWERR_MS;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			flash_ms_ff <= 9'h0;
			phase_ff    <= 1'b0;
		end else if (tick_ff) begin
			if (flash_ms_ff >= half_ms - 9'h1) begin
				flash_ms_ff <= 9'h0;
				phase_ff    <= ~phase_ff;
			end else begin
				flash_ms_ff <= flash_ms_ff + 9'h1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			led_yellow <= 1'b0;
			led_green  <= 1'b0;
		end else if (teach_flash) begin
			led_yellow <= phase_ff;
			led_green  <= ~phase_ff;
		end else if (state_ff == SEQ_HOLD && !hold_btn2_ff && press_ms_ff >= SINGLE_MIN_MS) begin
			led_yellow <= phase_ff;
			led_green  <= 1'b1;
		end else if (ana_err_ff) begin
			led_yellow <= phase_ff;
			led_green  <= phase_ff;
		end else if (sw_err_ff) begin
			led_yellow <= phase_ff;
			led_green  <= 1'b1;
		end else begin
			led_yellow <= switching_output;
			led_green  <= 1'b1;
		end
	end

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        aw_got_ff;
	logic        w_got_ff;
	logic        do_write;
	logic        wr_hit;
	logic [31:0] rd_word;
	logic        rd_hit;

	assign do_write = aw_got_ff & w_got_ff & ~s_axi_bvalid;
	assign wr_hit   = awaddr_ff == REG_CTRL || awaddr_ff == REG_INT_STAT
		|| awaddr_ff == REG_INT_MASK || awaddr_ff == REG_TI_SINGLE
		|| awaddr_ff == REG_TI_PAIR;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			aw_got_ff     <= 1'b0;
			w_got_ff      <= 1'b0;
			awaddr_ff     <= 8'h00;
			wdata_ff      <= 32'h0;
			wstrb_ff      <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_ff     <= {s_axi_awaddr[7:2], 2'b00};
				aw_got_ff     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_ff     <= s_axi_wdata;
				wstrb_ff     <= s_axi_wstrb;
				w_got_ff     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
				aw_got_ff    <= 1'b0;
				w_got_ff     <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Hardware events win over a same-cycle write-one-to-clear
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_ff      <= CTRL_RST;
			int_stat_ff  <= 4'h0;
			int_mask_ff  <= 4'h0;
			ti_single_ff <= TI_SINGLE_RST;
			ti_pair_ff   <= TI_PAIR_RST;
			irq          <= 1'b0;
		end else begin
			if (do_write && awaddr_ff == REG_CTRL && wstrb_ff[0])
				ctrl_ff <= wdata_ff[1:0];
			if (do_write && awaddr_ff == REG_INT_MASK && wstrb_ff[0])
				int_mask_ff <= wdata_ff[3:0];
			for (int b = 0; b < 4; b++) begin
				if (do_write && awaddr_ff == REG_TI_SINGLE && wstrb_ff[b])
					ti_single_ff[8*b +: 8] <= wdata_ff[8*b +: 8];
				if (do_write && awaddr_ff == REG_TI_PAIR && wstrb_ff[b])
					ti_pair_ff[8*b +: 8] <= wdata_ff[8*b +: 8];
			end
			if (do_write && awaddr_ff == REG_INT_STAT && wstrb_ff[0])
				int_stat_ff <= (int_stat_ff & ~wdata_ff[3:0]) | ev_ff;
			else
				int_stat_ff <= int_stat_ff | ev_ff;
			irq <= |(int_stat_ff & int_mask_ff);
		end
	end

	// Diagnostic read-out for the configuration link
	always_comb begin
		rd_word = 32'h0;
		rd_hit  = 1'b1;
		unique case ({s_axi_araddr[7:2], 2'b00})
			REG_CTRL:      rd_word = {30'h0, ctrl_ff};
			REG_STATUS:    rd_word = {23'h0, buttons_locked, window_mode_ff, nc_mode_ff,
				curve_falling_ff, sw_err_ff, ana_err_ff, 1'b0, state_ff};
			REG_INT_STAT:  rd_word = {28'h0, int_stat_ff};
			REG_INT_MASK:  rd_word = {28'h0, int_mask_ff};
			REG_ANA_START: rd_word = {16'h0, ana_start_ff};
			REG_ANA_END:   rd_word = {16'h0, ana_end_ff};
			REG_SW_POINT1: rd_word = {16'h0, sw_p1_ff};
			REG_SW_POINT2: rd_word = {16'h0, sw_p2_ff};
			REG_TI_SINGLE: rd_word = ti_single_ff;
			REG_TI_PAIR:   rd_word = ti_pair_ff;
			REG_DISTANCE:  rd_word = {15'h0, dist_valid, dist_mm};
			default:       rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? 2'b00 : 2'b10;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule // teach_control_sequencer

//--- rtl/teach_pkg.sv
// Constants shared by the teach sequencer and its input conditioner
package teach_pkg;
	// ************************************************************
	// Clock and time base
	// ************************************************************
	localparam int CLK_PERIOD_NS   = 10;
	localparam int TICK_PERIOD_NS  = 1000000;
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int DEBOUNCE_MS     = 10;

	// ************************************************************
	// Press durations in ms ticks
	// ************************************************************
	localparam logic [13:0] SINGLE_MIN_MS = 14'd2000;
	localparam logic [13:0] PAIR_MIN_MS   = 14'd7000;
	localparam logic [13:0] PAIR_MAX_MS   = 14'd12000;

	// ************************************************************
	// Flash rates, half periods in ms ticks (rounded down)
	// ************************************************************
	localparam int TEACH_HZ = 3;
	localparam int SWERR_HZ = 5;
	localparam int ANERR_HZ = 8;
	localparam logic [8:0] HALF_TEACH_MS = 9'(1000 / (2 * TEACH_HZ));
	localparam logic [8:0] HALF_SWERR_MS = 9'(1000 / (2 * SWERR_HZ));
	localparam logic [8:0] HALF_ANERR_MS = 9'(1000 / (2 * ANERR_HZ));

	// ************************************************************
	// Minimum gap between taught points, mm
	// ************************************************************
	localparam logic [15:0] MIN_GAP_400_MM  = 16'd40;
	localparam logic [15:0] MIN_GAP_1300_MM = 16'd130;

	// ************************************************************
	// Analog out-of-range codes
	// ************************************************************
	localparam logic [15:0] ANA_CLOSE_CODE = 16'hFFFE;
	localparam logic [15:0] ANA_FAR_CODE   = 16'hFFFF;

	// ************************************************************
	// Register map, byte offsets
	// ************************************************************
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_STATUS    = 8'h04;
	localparam logic [7:0] REG_INT_STAT  = 8'h08;
	localparam logic [7:0] REG_INT_MASK  = 8'h0C;
	localparam logic [7:0] REG_ANA_START = 8'h10;
	localparam logic [7:0] REG_ANA_END   = 8'h14;
	localparam logic [7:0] REG_SW_POINT1 = 8'h18;
	localparam logic [7:0] REG_SW_POINT2 = 8'h1C;
	localparam logic [7:0] REG_TI_SINGLE = 8'h20;
	localparam logic [7:0] REG_TI_PAIR   = 8'h24;
	localparam logic [7:0] REG_DISTANCE  = 8'h28;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [1:0]  CTRL_RST      = 2'h1;
	localparam logic [31:0] TI_SINGLE_RST = 32'h0050_0014;
	localparam logic [31:0] TI_PAIR_RST   = 32'h00B4_0078;

	// ************************************************************
	// Interrupt event bits
	// ************************************************************
	localparam int EV_ANA_DONE = 0;
	localparam int EV_ANA_ERR  = 1;
	localparam int EV_SW_DONE  = 2;
	localparam int EV_SW_ERR   = 3;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_HOLD = 2'b01,
		SEQ_PAIR = 2'b10
	} seq_state_t;

	typedef enum logic [1:0] {
		TGT_ANALOG = 2'b00,
		TGT_WINDOW = 2'b01,
		TGT_BOTH   = 2'b10
	} pair_target_t;
endpackage

//--- rtl/input_debounce.sv
// Two-stage synchroniser and stability filter for one slow pin
`timescale 1ns/10ps
module input_debounce #(
	parameter int STABLE_TICKS = 10
) (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic tick,
	input  wire logic pin,
	output logic      level
);
	logic       sync1_ff;
	logic       sync2_ff;
	logic [7:0] cnt_ff;

	if (STABLE_TICKS < 1 || STABLE_TICKS > 255) begin : g_chk
		$error("STABLE_TICKS out of range");
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= pin;
			sync2_ff <= sync1_ff;
		end
	end

	// A level must hold for whole ticks before it is believed
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_ff <= 8'h00;
			level  <= 1'b0;
		end else if (sync2_ff == level) begin
			cnt_ff <= 8'h00;
		end else if (tick) begin
			if (cnt_ff == 8'(STABLE_TICKS - 1)) begin
				level  <= sync2_ff;
				cnt_ff <= 8'h00;
			end else begin
				cnt_ff <= cnt_ff + 8'h01;
			end
		end
	end
endmodule // input_debounce

//--- dv/teach_asserts.sv
// Bus and output-code checks for the teach sequencer
`timescale 1ns/10ps
module teach_asserts (
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	input wire logic [15:0] analog_output,
	input wire logic        analog_too_close,
	input wire logic        analog_too_far,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_wvalid,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	import teach_pkg::*;
	// ****
	// Checks
	// ****
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	b_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	r_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	wr_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	rd_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	rd_slverr_a: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h0A |=> s_axi_rresp == 2'h2)
		else $error("unmapped read not refused");
	close_code_a: assert property (
		analog_too_close |-> analog_output == ANA_CLOSE_CODE && !analog_too_far)
		else $error("too close code wrong");
	far_code_a: assert property (analog_too_far |-> analog_output == ANA_FAR_CODE)
		else $error("too far code wrong");
	cover property (analog_too_close);
	cover property (analog_too_far);
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // teach_asserts

//--- dv/operator_model.sv
// Operator buttons and teach-input controller
`timescale 1ns/10ps
module operator_model #(
	parameter int TICK = 2
) (
	input  wire logic sys_clk,
	output logic      button1_pin,
	output logic      button2_pin,
	output logic      teach_in_pin
);
	logic [2:0] pins = 3'h0;
	assign {teach_in_pin, button2_pin, button1_pin} = pins;
	// Contact bounce shorter than the filter must not split a press
	task automatic press(input int which, input int ms);
		int k;
		for (k = 0; k < 5; k++) begin
			@(posedge sys_clk);
			pins[which] <= ~pins[which];
		end
		repeat (ms * TICK) @(posedge sys_clk);
		pins[which] <= 1'b0;
	endtask
	task automatic set_lock(input logic v);
		@(posedge sys_clk);
		pins[2] <= v;
	endtask
endmodule // operator_model

//--- dv/tb_top.sv
// Self-checking bench for the teach sequencer
`timescale 1ns/10ps
module tb_top;
	import teach_pkg::*;
	localparam int TK = 2;
	logic        sys_clk = 0;
	logic        sys_rst = 1;
	wire         button1_pin, button2_pin, teach_in_pin;
	logic [15:0] dist_mm = 16'h0064;
	logic        dist_valid = 1;
	wire         switching_output, analog_too_close, analog_too_far, led_yellow, led_green, irq;
	wire  [15:0] analog_output;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	int          n_fail = 0;
	int          total_checks = 0;
	logic [31:0] rd;
	logic [1:0]  rr;
	always #5 sys_clk = ~sys_clk;
	teach_control_sequencer #(.TICK_CYCLES(TK)) i_teach_control_sequencer (.*);
	operator_model #(.TICK(TK)) i_operator_model (.*);
	// ****
	// Helpers
	// ****
	task automatic test_done;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic ms(input int n);
		repeat (n * TK) @(posedge sys_clk);
	endtask
	// Ready is looked at on the falling edge, so the rising edge after it is the handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		logic aw, w, b;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		i = 0;
		do begin
			@(negedge sys_clk);
			aw = s_axi_awready & s_axi_awvalid;
			w = s_axi_wready & s_axi_wvalid;
			b = s_axi_bvalid;
			@(posedge sys_clk);
			if (aw) s_axi_awvalid <= 0;
			if (w) s_axi_wvalid <= 0;
			i++;
		end while (!b && i < 50);
		s_axi_bready <= 0;
		if (!b) begin
			chk("bvalid", 1, b);
			test_done;
		end
	endtask
	task automatic rdr(input logic [7:0] a);
		int i;
		logic ar, rv;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		i = 0;
		do begin
			@(negedge sys_clk);
			ar = s_axi_arready & s_axi_arvalid;
			rv = s_axi_rvalid;
			rd = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge sys_clk);
			if (ar) s_axi_arvalid <= 0;
			i++;
		end while (!rv && i < 50);
		s_axi_rready <= 0;
		if (!rv) begin
			chk("rvalid", 1, rv);
			test_done;
		end
	endtask
	task automatic teach2(input logic [15:0] p1, input logic [15:0] p2);
		dist_mm <= p1;
		i_operator_model.press(1, 7500);
		ms(50);
		rdr(REG_STATUS);
		chk("state", SEQ_PAIR, rd[1:0]);
		chk("alternate", 1, led_yellow ^ led_green);
		dist_mm <= p2;
		i_operator_model.press(1, 200);
		ms(50);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_regs;
		rdr(REG_CTRL);
		chk("ctrl", 1, rd);
		rdr(REG_TI_SINGLE);
		chk("ti_single", TI_SINGLE_RST, rd);
		rdr(8'h40);
		chk("unmapped", 2, rr);
		wr(REG_INT_MASK, 32'h0000_0003);
	endtask
	task automatic t_rising;
		teach2(16'h0064, 16'h012C);
		rdr(REG_STATUS);
		chk("rise status", 0, rd[5:0]);
		rdr(REG_ANA_END);
		chk("end", 16'h012C, rd);
		chk("irq", 1, irq);
		dist_mm <= 16'h00C8;
		ms(2);
		chk("rise out", 16'h0064, analog_output);
		dist_mm <= 16'h0032;
		ms(2);
		chk("close", 1, analog_too_close);
		chk("close code", ANA_CLOSE_CODE, analog_output);
		dist_mm <= 16'h0190;
		ms(2);
		chk("far", ANA_FAR_CODE, analog_output);
		chk("far flag", 1, analog_too_far);
		wr(REG_INT_STAT, 32'h0000_000F);
		ms(1);
		chk("irq clr", 0, irq);
	endtask
	task automatic t_fault;
		int n;
		logic p;
		teach2(16'h0064, 16'h0078);
		rdr(REG_INT_STAT);
		chk("err ev", 2, rd[1:0]);
		n = 0;
		p = led_yellow;
		repeat (500 * TK) begin
			@(negedge sys_clk);
			if (led_yellow !== led_green) n = 99;
			if (led_yellow !== p) n++;
			p = led_yellow;
		end
		chk("8 Hz", 1, n >= 6 && n < 12);
	endtask
	task automatic t_falling;
		teach2(16'h012C, 16'h0064);
		rdr(REG_STATUS);
		chk("fall status", 6'h20, rd[5:0]);
		dist_mm <= 16'h00FA;
		ms(2);
		chk("fall out", 16'h0032, analog_output);
	endtask
	task automatic t_lock;
		i_operator_model.set_lock(1);
		ms(50);
		i_operator_model.press(1, 7500);
		ms(50);
		rdr(REG_STATUS);
		chk("locked", 9'h120, rd[8:0]);
		i_operator_model.set_lock(0);
		ms(50);
		rdr(REG_STATUS);
		chk("unlocked", 0, rd[8]);
	endtask
	task automatic ti_pulse(input int n);
		i_operator_model.set_lock(1);
		ms(n);
		i_operator_model.set_lock(0);
		ms(20);
	endtask
	task automatic t_ti;
		dist_mm <= 16'h0064;
		ti_pulse(40);
		rdr(REG_SW_POINT1);
		chk("sw point", 16'h0064, rd);
		dist_mm <= 16'h0032;
		ms(2);
		chk("sw on", 1, switching_output);
		ti_pulse(150);
		dist_mm <= 16'h00C8;
		ti_pulse(150);
		rdr(REG_STATUS);
		chk("both status", 8'hA0, rd[7:0]);
		rdr(REG_SW_POINT2);
		chk("window", 16'h00C8, rd);
		rdr(REG_ANA_START);
		chk("curve", 16'h0032, rd);
		dist_valid <= 0;
		ti_pulse(40);
		dist_valid <= 1;
		ms(2);
		chk("sw err", 0, switching_output);
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		sys_rst <= 0;
		t_regs;
		t_rising;
		t_fault;
		t_falling;
		t_lock;
		t_ti;
		test_done;
	end
endmodule // tb_top
bind teach_control_sequencer teach_asserts i_teach_asserts (.*);
